// *** hdl/customer_mem.sv ***
// Customer scratch memory, one write and one registered read port
`timescale 1ns/10ps
module customer_mem
  import supervisor_pkg::*;
(
  input wire logic clk_in,
  input wire logic wr_en_in,
  input wire logic [MEM_AW-1:0] waddr_in,
  input wire logic [7:0] wdata_in,
  input wire logic [MEM_AW-1:0] raddr_in,
  output logic [7:0] rdata_out
);
  logic [7:0] mem_reg [MEM_DEPTH];

  // Contents are not reset; the host owns them
  always_ff @(posedge clk_in) begin
    if (wr_en_in) begin
      mem_reg[waddr_in] <= wdata_in;
    end
    rdata_out <= mem_reg[raddr_in];
  end
endmodule : customer_mem

// *** hdl/dual_master_supervisor.sv ***
// Dual-host control selector, restart sequencer and front LED logic
`timescale 1ns/10ps
module dual_master_supervisor
  import supervisor_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
  input wire logic SYS_CLK_IN,
  input wire logic SYS_RST_IN,
  input wire logic LINK_CLK_IN,
  input wire logic BUS0_STB_IN,
  input wire logic [1:0] BUS0_KIND_IN,
  input wire logic [7:0] BUS0_DATA_IN,
  input wire logic BUS0_PEC_OK_IN,
  input wire logic BUS1_STB_IN,
  input wire logic [1:0] BUS1_KIND_IN,
  input wire logic [7:0] BUS1_DATA_IN,
  input wire logic BUS1_PEC_OK_IN,
  input wire logic ENABLE_IN,
  input wire logic PRESENT_IN,
  input wire logic INPUT_OK_IN,
  input wire logic OV_FAULT_IN,
  input wire logic OT_FAULT_IN,
  input wire logic OC_FAULT_IN,
  input wire logic OVERLOAD_IN,
  input wire logic VOUT_ABOVE_36V_IN,
  input wire logic OPER_ON_IN,
  input wire logic LATCH_OV_IN,
  input wire logic LATCH_OT_IN,
  input wire logic LATCH_OC_IN,
  input wire logic NV_LATCH_DEFAULT_IN,
  output logic [7:0] BUS0_RDATA_OUT,
  output logic BUS0_ACK_OUT,
  output logic BUS0_ALERT_N_OUT,
  output logic [7:0] BUS1_RDATA_OUT,
  output logic BUS1_ACK_OUT,
  output logic BUS1_ALERT_N_OUT,
  output logic POWER_ON_OUT,
  output logic CC_HOLD_OUT,
  output logic ALARM_CLEAR_OUT,
  output logic RESTART_OK_OUT,
  output logic OUTPUT_LED_OUT,
  output logic SERVICE_LED_OUT,
  output logic FAULT_LED_OUT,
  output logic INPUT_LED_OUT,
  output logic STRETCH_OUT,
  output logic ORING_TEST_OUT
);
  localparam logic [19:0] TICK_LAST = 20'(TICK_CYCLES - 1);

  // ==========================================================
  // Link domain: one word per strobe, announced by a toggle
  wire lk_rst;
  wire [1:0] lk_stb = {BUS1_STB_IN, BUS0_STB_IN};
  wire [1:0][LINK_W-1:0] lk_word = {{BUS1_KIND_IN, BUS1_DATA_IN, BUS1_PEC_OK_IN},
                                    {BUS0_KIND_IN, BUS0_DATA_IN, BUS0_PEC_OK_IN}};
  logic [1:0] lk_tog_reg;
  logic [1:0][LINK_W-1:0] lk_word_reg;

  level_sync #(.W(1)) u_lk_rst (
    .clk_in(LINK_CLK_IN),
    .rst_in(1'b0),
    .d_in(SYS_RST_IN),
    .q_out(lk_rst)
  );

  // Each port has its own capture, so a stuck port cannot stall the other
  always_ff @(posedge LINK_CLK_IN) begin
    if (lk_rst) begin
      lk_tog_reg <= 2'h0;
    end else begin
      lk_tog_reg <= lk_tog_reg ^ lk_stb;
    end
  end

  // Held stable until the host sees the acknowledge toggle
  always_ff @(posedge LINK_CLK_IN) begin
    for (int b = 0; b < 2; b++) begin
      if (lk_stb[b]) begin
        lk_word_reg[b] <= lk_word[b];
      end
    end
  end

  // ==========================================================
  // Crossings into the system clock
  wire [1:0] tog_s;
  wire [7:0] pin_s;
  logic [1:0] tog_prev_reg;

  level_sync #(.W(2)) u_tog (
    .clk_in(SYS_CLK_IN),
    .rst_in(SYS_RST_IN),
    .d_in(lk_tog_reg),
    .q_out(tog_s)
  );

  level_sync #(.W(8)) u_pins (
    .clk_in(SYS_CLK_IN),
    .rst_in(SYS_RST_IN),
    .d_in({VOUT_ABOVE_36V_IN, OVERLOAD_IN, OC_FAULT_IN, OT_FAULT_IN,
           OV_FAULT_IN, INPUT_OK_IN, PRESENT_IN, ENABLE_IN}),
    .q_out(pin_s)
  );

  wire en_s = pin_s[0];
  wire present_s = pin_s[1];
  wire inok_s = pin_s[2];
  wire f_ov = pin_s[3];
  wire f_ot = pin_s[4];
  wire f_oc = pin_s[5];
  wire overload = pin_s[6];
  wire vhi = pin_s[7];
  wire [1:0] ev = tog_s ^ tog_prev_reg;

  // ==========================================================
  // Per-port command decode
  logic ctrl_reg;
  logic [1:0] busy_reg, ok_reg, req_reg, err_reg, sel_alert_reg, alert_n_reg;
  logic [1:0][7:0] cmd_reg, wbuf_reg, cnt_reg, rdata_reg;
  logic [1:0][1:0] idx_reg;
  logic [1:0][MEM_AW-1:0] addr_reg;
  logic [1:0] ack_reg;
  logic [7:0] test_reg;
  logic fault_alert_reg;
  wire [7:0] mem_rdata;
  wire [7:0] bus_state;
  wire [1:0][1:0] kind;
  wire [1:0][7:0] data;
  wire [1:0] pec, is_ctrl, allowed, cmd_ev, dat_ev, end_ev, rd_ev;
  wire [1:0] bad_cmd, takeover_ok, clr_ev, tf_wr, mem_wr;
  wire [1:0][7:0] rd_mux;

  function automatic logic [7:0] read_sel(input logic [7:0] cmd, input logic [7:0] st,
                                          input logic [7:0] tf, input logic [7:0] md);
    read_sel = (cmd == CMD_BUS_STATE) ? st : (cmd == CMD_TEST_FUNC) ? tf :
               (cmd == CMD_MEM_WRITE) ? md : 8'h00;
  endfunction : read_sel

  for (genvar b = 0; b < 2; b++) begin : g_bus
    assign kind[b] = lk_word_reg[b][LINK_W-1:LK_KIND_LSB];
    assign data[b] = lk_word_reg[b][LK_KIND_LSB-1:LK_DATA_LSB];
    assign pec[b] = lk_word_reg[b][LK_PEC_BIT];
    assign is_ctrl[b] = (ctrl_reg == 1'(b));
    assign allowed[b] = is_ctrl[b] | (data[b] == CMD_TAKEOVER)
                        | (data[b] == CMD_CLEAR_FAULTS);
    assign cmd_ev[b] = ev[b] & (kind[b] == LK_CMD);
    assign dat_ev[b] = ev[b] & (kind[b] == LK_DATA) & ok_reg[b];
    assign end_ev[b] = ev[b] & (kind[b] == LK_END);
    assign rd_ev[b] = ev[b] & (kind[b] == LK_READ);
    assign bad_cmd[b] = cmd_ev[b] & ~allowed[b];
    assign takeover_ok[b] = end_ev[b] & ok_reg[b] & pec[b] & ~is_ctrl[b]
                            & (cmd_reg[b] == CMD_TAKEOVER);
    assign clr_ev[b] = end_ev[b] & ok_reg[b] & (cmd_reg[b] == CMD_CLEAR_FAULTS);
    assign tf_wr[b] = end_ev[b] & ok_reg[b] & is_ctrl[b] & (idx_reg[b] != 2'h0)
                      & (cmd_reg[b] == CMD_TEST_FUNC);
    assign mem_wr[b] = dat_ev[b] & is_ctrl[b] & (cmd_reg[b] == CMD_MEM_WRITE)
                       & (idx_reg[b] == 2'h2) & (cnt_reg[b] != 8'h00);
    assign rd_mux[b] = read_sel(data[b], bus_state, test_reg, mem_rdata);
    assign bus_state[b*BS_STRIDE+BS_HAS] = is_ctrl[b];
    assign bus_state[b*BS_STRIDE+BS_REQ] = req_reg[b];
    assign bus_state[b*BS_STRIDE+BS_ALERT] = ~alert_n_reg[b];
    assign bus_state[b*BS_STRIDE+BS_ERR] = err_reg[b];
  end

  // Transaction tracking; reads never mark a port busy
  always_ff @(posedge SYS_CLK_IN) begin
    if (SYS_RST_IN) begin
      tog_prev_reg <= 2'h0;
      busy_reg <= 2'h0;
      ok_reg <= 2'h0;
      cmd_reg <= '0;
      idx_reg <= '0;
      wbuf_reg <= '0;
      cnt_reg <= '0;
      addr_reg <= '0;
      rdata_reg <= '0;
      ack_reg <= 2'h0;
    end else begin
      tog_prev_reg <= tog_s;
      ack_reg <= ack_reg ^ ev;
      for (int b = 0; b < 2; b++) begin
        if (cmd_ev[b]) begin
          cmd_reg[b] <= data[b];
          ok_reg[b] <= allowed[b];
          busy_reg[b] <= 1'b1;
          idx_reg[b] <= 2'h0;
        end
        if (dat_ev[b]) begin
          if (idx_reg[b] == 2'h0) begin
            addr_reg[b] <= data[b][MEM_AW-1:0];
            wbuf_reg[b] <= data[b];
          end
          if (idx_reg[b] == 2'h1) begin
            cnt_reg[b] <= data[b];
          end
          if (idx_reg[b] != 2'h2) begin
            idx_reg[b] <= idx_reg[b] + 2'h1;
          end else if (cnt_reg[b] != 8'h00) begin
            addr_reg[b] <= addr_reg[b] + 7'h01;
            cnt_reg[b] <= cnt_reg[b] - 8'h01;
          end
        end
        if (end_ev[b]) begin
          busy_reg[b] <= 1'b0;
        end
        if (rd_ev[b]) begin
          rdata_reg[b] <= rd_mux[b];
        end
      end
    end
  end

  customer_mem u_mem (
    .clk_in(SYS_CLK_IN),
    .wr_en_in(mem_wr[ctrl_reg]),
    .waddr_in(addr_reg[ctrl_reg]),
    .wdata_in(data[ctrl_reg]),
    .raddr_in(addr_reg[ctrl_reg]),
    .rdata_out(mem_rdata)
  );

  // ==========================================================
  // Control selector and alert sources
  wire other = ~ctrl_reg;
  wire grant = req_reg[other] & ~busy_reg[ctrl_reg];
  wire [1:0] sel_alert_next = {2{grant}} | (sel_alert_reg & ~clr_ev);
  wire [1:0] err_next = bad_cmd | (err_reg & ~clr_ev);
  wire [1:0] req_next = (req_reg | takeover_ok) & ~{2{grant}};
  wire fault_rise;
  wire fault_next = fault_rise | (fault_alert_reg & ~clr_ev[ctrl_reg]);

  // Set beats clear on the alert and error flags, so no event is lost; on req_reg the grant clear wins
  always_ff @(posedge SYS_CLK_IN) begin
    if (SYS_RST_IN) begin
      ctrl_reg <= 1'b0;
      req_reg <= 2'h0;
      err_reg <= 2'h0;
      sel_alert_reg <= 2'h0;
      fault_alert_reg <= 1'b0;
      alert_n_reg <= 2'h3;
      test_reg <= TF_RESET;
    end else begin
      ctrl_reg <= grant ? other : ctrl_reg;
      req_reg <= req_next;
      err_reg <= err_next;
      sel_alert_reg <= sel_alert_next;
      fault_alert_reg <= fault_next;
      alert_n_reg <= ~(sel_alert_next | {2{fault_next}});
      if (tf_wr[ctrl_reg]) begin
        test_reg <= wbuf_reg[ctrl_reg] & TF_WRITE_MASK;
      end
    end
  end

  // ==========================================================
  // Millisecond tick; shorten TICK_CYCLES in simulation
  logic [19:0] tick_cnt_reg;
  wire tick = (tick_cnt_reg == TICK_LAST);

  always_ff @(posedge SYS_CLK_IN) begin
    if (SYS_RST_IN || tick) begin
      tick_cnt_reg <= 20'h0;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 20'h1;
    end
  end

  // ==========================================================
  // Restart sequencer
  pwr_state_e pwr_reg, pwr_next;
  ms_t st_ms_reg, win_ms_reg;
  logic [1:0] ov_cnt_reg;
  logic st_clr, shut_ev, f_any_prev_reg;
  wire run_req = en_s & OPER_ON_IN & inok_s & present_s;
  wire latch_ov = LATCH_OV_IN | NV_LATCH_DEFAULT_IN;
  wire latch_ot = LATCH_OT_IN | NV_LATCH_DEFAULT_IN;
  wire latch_oc = LATCH_OC_IN | NV_LATCH_DEFAULT_IN;
  wire limit = overload | f_oc;
  wire trip_start = f_ov | f_ot | (limit & reached(st_ms_reg, CC_HOLD_MS));
  wire trip_on = f_ov | f_ot | f_oc | (overload & ~vhi);
  wire latch_hit = f_ov ? (latch_ov | (ov_cnt_reg == OV_LAST_TRY)) :
                   f_ot ? latch_ot : latch_oc;
  wire shut_to = latch_hit;
  wire restart_ok = (pwr_reg == PS_START) & (pwr_next == PS_ON);
  wire f_any = f_ov | f_ot | f_oc;
  assign fault_rise = f_any & ~f_any_prev_reg;

  always_comb begin
    pwr_next = pwr_reg;
    shut_ev = 1'b0;
    unique case (pwr_reg)
      PS_OFF: begin
        if (run_req && reached(st_ms_reg, OFF_MIN_MS)) begin
          pwr_next = PS_START;
        end
      end
      PS_START: begin
        if (!run_req) begin
          pwr_next = PS_OFF;
        end else if (trip_start) begin
          shut_ev = 1'b1;
        end else if (!limit) begin
          pwr_next = PS_ON;
        end
      end
      PS_ON: begin
        if (!run_req) begin
          pwr_next = PS_OFF;
        end else if (trip_on) begin
          shut_ev = 1'b1;
        end
      end
      PS_RETRY: begin
        if (!run_req) begin
          pwr_next = PS_OFF;
        end else if (reached(st_ms_reg, RETRY_MS)) begin
          pwr_next = PS_START;
        end
      end
      PS_LATCHED: begin
        if (!run_req) begin
          pwr_next = PS_OFF;
        end
      end
      default: pwr_next = PS_OFF;
    endcase
    if (shut_ev) begin
      pwr_next = shut_to ? PS_LATCHED : PS_RETRY;
    end
    // An off period cut short must start over
    st_clr = (pwr_next != pwr_reg) || ((pwr_reg == PS_OFF) && run_req);
  end

  // Reset counts as a full power cycle, so the first start needs no wait
  always_ff @(posedge SYS_CLK_IN) begin
    if (SYS_RST_IN) begin
      pwr_reg <= PS_OFF;
      st_ms_reg <= OFF_MIN_MS;
      f_any_prev_reg <= 1'b0;
    end else begin
      pwr_reg <= pwr_next;
      f_any_prev_reg <= f_any;
      if (st_clr) begin
        st_ms_reg <= '0;
      end else if (tick) begin
        st_ms_reg <= sat_inc(st_ms_reg);
      end
    end
  end

  // Overvoltage shutdowns counted inside a one-minute window opened by the first of them
  always_ff @(posedge SYS_CLK_IN) begin
    if (SYS_RST_IN || pwr_reg == PS_LATCHED) begin
      ov_cnt_reg <= 2'h0;
      win_ms_reg <= '0;
    end else if (shut_ev && f_ov) begin
      ov_cnt_reg <= ov_cnt_reg + 2'h1;
      win_ms_reg <= (ov_cnt_reg == 2'h0) ? '0 : win_ms_reg;
    end else if (tick && ov_cnt_reg != 2'h0) begin
      if (reached(win_ms_reg, OV_WINDOW_MS)) begin
        ov_cnt_reg <= 2'h0;
      end else begin
        win_ms_reg <= sat_inc(win_ms_reg);
      end
    end
  end

  // ==========================================================
  // Indicators, stretch and outputs
  ms_t flash_ms_reg, lt_ms_reg, str_ms_reg;
  logic flash_reg;
  wire lt_on_bit = test_reg[TF_LEDTEST];
  wire lt_lamp = lt_on_bit & ~reached(lt_ms_reg, LEDTEST_ON_MS);
  wire lt_wrap = reached(lt_ms_reg, LEDTEST_ON_MS + LEDTEST_OFF_MS - 17'h1);
  wire powered = (pwr_reg == PS_START) | (pwr_reg == PS_ON);
  wire out_lamp = powered & ~(limit & vhi & ~flash_reg);
  wire svc_lamp = test_reg[TF_SERVICE] & flash_reg;
  wire stretching = (str_ms_reg != '0);
  wire any_end = |end_ev;

  // Blink and test cadences run on the millisecond tick
  always_ff @(posedge SYS_CLK_IN) begin
    if (SYS_RST_IN) begin
      flash_ms_reg <= '0;
      flash_reg <= 1'b1;
      lt_ms_reg <= '0;
      str_ms_reg <= '0;
    end else begin
      if (tick) begin
        flash_ms_reg <= reached(flash_ms_reg, FLASH_HALF_MS - 17'h1) ? '0 :
                        sat_inc(flash_ms_reg);
        flash_reg <= reached(flash_ms_reg, FLASH_HALF_MS - 17'h1) ? ~flash_reg : flash_reg;
      end
      if (!lt_on_bit) begin
        lt_ms_reg <= '0;
      end else if (tick) begin
        lt_ms_reg <= lt_wrap ? '0 : sat_inc(lt_ms_reg);
      end
      if (any_end && test_reg[TF_STRETCH]) begin
        str_ms_reg <= STRETCH_MS;
      end else if (tick && stretching) begin
        str_ms_reg <= ms_t'(str_ms_reg - 17'h1);
      end
    end
  end

  // Every top-level output leaves from a flip-flop
  always_ff @(posedge SYS_CLK_IN) begin
    if (SYS_RST_IN) begin
      POWER_ON_OUT <= 1'b0;
      CC_HOLD_OUT <= 1'b0;
      ALARM_CLEAR_OUT <= 1'b0;
      RESTART_OK_OUT <= 1'b0;
      OUTPUT_LED_OUT <= 1'b0;
      SERVICE_LED_OUT <= 1'b0;
      FAULT_LED_OUT <= 1'b0;
      INPUT_LED_OUT <= 1'b0;
      STRETCH_OUT <= 1'b0;
      ORING_TEST_OUT <= 1'b0;
    end else begin
      POWER_ON_OUT <= powered;
      CC_HOLD_OUT <= (pwr_reg == PS_START) & limit;
      ALARM_CLEAR_OUT <= restart_ok;
      RESTART_OK_OUT <= restart_ok | (RESTART_OK_OUT & ~clr_ev[ctrl_reg]);
      OUTPUT_LED_OUT <= lt_on_bit ? lt_lamp : out_lamp;
      SERVICE_LED_OUT <= lt_on_bit ? lt_lamp : svc_lamp;
      FAULT_LED_OUT <= lt_on_bit ? lt_lamp : fault_alert_reg;
      INPUT_LED_OUT <= lt_on_bit ? lt_lamp : inok_s;
      STRETCH_OUT <= stretching;
      ORING_TEST_OUT <= test_reg[TF_ORING];
    end
  end

  assign BUS0_RDATA_OUT = rdata_reg[0];
  assign BUS1_RDATA_OUT = rdata_reg[1];
  assign BUS0_ACK_OUT = ack_reg[0];
  assign BUS1_ACK_OUT = ack_reg[1];
  assign BUS0_ALERT_N_OUT = alert_n_reg[0];
  assign BUS1_ALERT_N_OUT = alert_n_reg[1];
endmodule : dual_master_supervisor

// *** hdl/level_sync.sv ***
// Two-flop synchroniser for levels entering a clock domain
`timescale 1ns/10ps
module level_sync #(
  parameter int W = 1
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  logic [W-1:0] meta_reg;

  // First stage feeds only the second stage
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      meta_reg <= '0;
      q_out <= '0;
    end else begin
      meta_reg <= d_in;
      q_out <= meta_reg;
    end
  end
endmodule : level_sync

// *** hdl/supervisor_pkg.sv ***
// Constants, types and helpers for the dual-host supervisor
package supervisor_pkg;
  // ==========================================================
  // Clock and time base
  localparam int CLK_HZ = 10_000_000;
  localparam int TICK_US = 1000;
  localparam int TICK_CYCLES_DEF = CLK_HZ / 1_000_000 * TICK_US;
  typedef logic [16:0] ms_t;
  localparam ms_t CC_HOLD_MS = 17'h04e20;
  localparam ms_t OFF_MIN_MS = 17'h007d0;
  localparam ms_t RETRY_MS = 17'h003e8;
  localparam ms_t OV_WINDOW_MS = 17'h0ea60;
  localparam ms_t LEDTEST_ON_MS = 17'h01b58;
  localparam ms_t LEDTEST_OFF_MS = 17'h007d0;
  localparam ms_t FLASH_HALF_MS = 17'h001f4;
  localparam ms_t STRETCH_MS = 17'h00019;
  localparam logic [1:0] OV_LAST_TRY = 2'h2;

  // ==========================================================
  // Host commands and register layout
  localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0] CMD_BUS_STATE = 8'hd7;
  localparam logic [7:0] CMD_TAKEOVER = 8'hd8;
  localparam logic [7:0] CMD_MEM_WRITE = 8'hd9;
  localparam logic [7:0] CMD_TEST_FUNC = 8'hdf;
  localparam int TF_STRETCH = 7;
  localparam int TF_ORING = 4;
  localparam int TF_SERVICE = 1;
  localparam int TF_LEDTEST = 0;
  localparam logic [7:0] TF_WRITE_MASK = 8'h93;
  localparam logic [7:0] TF_RESET = 8'h00;
  localparam int BS_HAS = 0;
  localparam int BS_REQ = 1;
  localparam int BS_ALERT = 2;
  localparam int BS_ERR = 3;
  localparam int BS_STRIDE = 4;
  localparam int MEM_DEPTH = 128;
  localparam int MEM_AW = 7;

  // ==========================================================
  // Link word: kind, data byte, PEC verdict
  localparam int LINK_W = 11;
  localparam int LK_KIND_LSB = 9;
  localparam int LK_DATA_LSB = 1;
  localparam int LK_PEC_BIT = 0;
  typedef enum logic [1:0] {
    LK_CMD = 2'h0, LK_DATA = 2'h1, LK_END = 2'h3, LK_READ = 2'h2
  } link_kind_e;

  // Power sequencer states, Gray along off-start-on-retry
  typedef enum logic [2:0] {
    PS_OFF = 3'h0, PS_START = 3'h1, PS_ON = 3'h3, PS_RETRY = 3'h2, PS_LATCHED = 3'h6
  } pwr_state_e;

  // ==========================================================
  // Millisecond timer helpers
  function automatic ms_t sat_inc(input ms_t v);
    sat_inc = (v == '1) ? v : ms_t'(v + 17'h1);
  endfunction : sat_inc

  function automatic logic reached(input ms_t v, input ms_t lim);
    reached = (v >= lim);
  endfunction : reached
endpackage : supervisor_pkg

// *** tb/host_pair_model.sv ***
// Two host controllers on the link side
`timescale 1ns/10ps
module host_pair_model (
  input wire logic lclk_in,
  input wire logic [1:0] ack_in,
  output logic [1:0] stb_out,
  output logic [1:0][1:0] kind_out,
  output logic [1:0][7:0] data_out,
  output logic [1:0] pec_out
);
  // Idle at time zero
  initial begin
    stb_out = 2'h0;
    kind_out = '0;
    data_out = '0;
    pec_out = 2'h0;
  end
  // One word per strobe; next after the ack toggle, or after 64 link clocks without it
  task automatic xfer(input int p, input logic [1:0] k, input logic [7:0] d, input logic ok);
    logic a0;
    int n;
    a0 = ack_in[p];
    n = 0;
    @(posedge lclk_in);
    stb_out[p] <= 1'b1;
    kind_out[p] <= k;
    data_out[p] <= d;
    pec_out[p] <= ok;
    @(posedge lclk_in);
    stb_out[p] <= 1'b0;
    kind_out[p] <= ~k; // Released lines show junk
    data_out[p] <= ~d;
    pec_out[p] <= ~ok;
    while (ack_in[p] === a0 && n < 64) begin
      @(posedge lclk_in);
      n++;
    end
  endtask : xfer
endmodule : host_pair_model

// *** tb/supervisor_sva.sv ***
// Port checker for the dual-host supervisor
`timescale 1ns/10ps
module supervisor_sva
  import supervisor_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
  input wire logic SYS_CLK_IN,
  input wire logic SYS_RST_IN,
  input wire logic BUS0_ACK_OUT,
  input wire logic BUS1_ACK_OUT,
  input wire logic POWER_ON_OUT,
  input wire logic CC_HOLD_OUT,
  input wire logic ALARM_CLEAR_OUT,
  input wire logic RESTART_OK_OUT,
  input wire logic OUTPUT_LED_OUT,
  input wire logic SERVICE_LED_OUT,
  input wire logic FAULT_LED_OUT,
  input wire logic STRETCH_OUT,
  input wire logic ORING_TEST_OUT
);
  default clocking @(posedge SYS_CLK_IN); endclocking
  default disable iff (SYS_RST_IN);
  // ====================
  // Helpers
  int svc_cnt;
  int cc_cnt;
  logic [1:0] ack_q;
  logic [1:0] ack_qq;
  wire logic ack_near = ({BUS1_ACK_OUT, BUS0_ACK_OUT} != ack_qq);
  // Run counters: long holds are too deep to unroll as repetitions
  always_ff @(posedge SYS_CLK_IN) begin
    svc_cnt <= (SERVICE_LED_OUT && !FAULT_LED_OUT) ? svc_cnt + 1 : 0;
    cc_cnt <= CC_HOLD_OUT ? cc_cnt + 1 : 0;
    ack_q <= {BUS1_ACK_OUT, BUS0_ACK_OUT};
    ack_qq <= ack_q;
  end
  sequence off_run;
    !POWER_ON_OUT [*3];
  endsequence
  // ====================
  // Properties
  oring_sync_a: assert property ($changed(ORING_TEST_OUT) |-> ack_near)
    else $error("or-ing test moved without a host word");
  stretch_sync_a: assert property ($rose(STRETCH_OUT) |-> ack_near)
    else $error("stretch began without a host word");
  svc_half_a: assert property (svc_cnt <= int'(FLASH_HALF_MS) * TICK_CYCLES + 2)
    else $error("service flash stayed lit too long");
  clear_pulse_a: assert property (ALARM_CLEAR_OUT |=> !ALARM_CLEAR_OUT)
    else $error("alarm clear longer than one cycle");
  clear_sets_ok_a: assert property (ALARM_CLEAR_OUT |-> ##[0:1] RESTART_OK_OUT)
    else $error("restart flag missing after alarm clear");
  cc_power_a: assert property (CC_HOLD_OUT |-> POWER_ON_OUT)
    else $error("current hold while output off");
  cc_len_a: assert property (cc_cnt <= int'(CC_HOLD_MS) * TICK_CYCLES + 2)
    else $error("current hold outlived its limit");
  led_off_a: assert property (off_run ##0 !SERVICE_LED_OUT |-> !OUTPUT_LED_OUT)
    else $error("output lamp lit while unit off");
endmodule : supervisor_sva

bind dual_master_supervisor supervisor_sva #(.TICK_CYCLES(TICK_CYCLES)) u_supervisor_sva (
  .SYS_CLK_IN, .SYS_RST_IN, .BUS0_ACK_OUT, .BUS1_ACK_OUT, .POWER_ON_OUT, .CC_HOLD_OUT,
  .ALARM_CLEAR_OUT, .RESTART_OK_OUT, .OUTPUT_LED_OUT, .SERVICE_LED_OUT, .FAULT_LED_OUT,
  .STRETCH_OUT, .ORING_TEST_OUT
);

// *** tb/tb_top.sv ***
// Self-checking bench for the dual-host supervisor
`timescale 1ns/10ps
module tb_top;
  import supervisor_pkg::*;
  localparam int T = 4;
  logic clk = 1'b0;
  logic lclk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] run = 2'h3;
  logic [2:0] flt = 3'h0;
  logic [2:0] lat = 3'h0;
  logic [1:0] stb;
  logic [1:0][1:0] kd;
  logic [1:0][7:0] dt;
  logic [1:0] pe;
  logic [1:0][7:0] rdv;
  logic [1:0] ack;
  logic [1:0] al;
  logic pwr, rok, ol, sl, fl, il, strch, orng;
  logic [7:0] r;
  logic [7:0] v;
  logic sp = 1'b0;
  logic [31:0] seed = 32'h000076cc;
  int error_cnt = 0;
  int n_compared = 0;
  int cyc = 0;
  int n;
  wire logic [4:0] obs = {pwr, ol, sl, fl, il};
  // Clocks with unrelated phases
  always #50 clk = ~clk;
  always #80 lclk = ~lclk;
  dual_master_supervisor #(.TICK_CYCLES(T)) u_dual_master_supervisor (
    .SYS_CLK_IN(clk), .SYS_RST_IN(rst), .LINK_CLK_IN(lclk),
    .BUS0_STB_IN(stb[0]), .BUS0_KIND_IN(kd[0]), .BUS0_DATA_IN(dt[0]), .BUS0_PEC_OK_IN(pe[0]),
    .BUS1_STB_IN(stb[1]), .BUS1_KIND_IN(kd[1]), .BUS1_DATA_IN(dt[1]), .BUS1_PEC_OK_IN(pe[1]),
    .ENABLE_IN(run[0]), .PRESENT_IN(1'b1), .INPUT_OK_IN(1'b1), .OV_FAULT_IN(flt[0]),
    .OT_FAULT_IN(flt[1]), .OC_FAULT_IN(flt[2]), .OVERLOAD_IN(1'b0), .VOUT_ABOVE_36V_IN(1'b0),
    .OPER_ON_IN(run[1]), .LATCH_OV_IN(lat[0]), .LATCH_OT_IN(lat[1]), .LATCH_OC_IN(lat[2]),
    .NV_LATCH_DEFAULT_IN(1'b0), .BUS0_RDATA_OUT(rdv[0]), .BUS0_ACK_OUT(ack[0]),
    .BUS0_ALERT_N_OUT(al[0]), .BUS1_RDATA_OUT(rdv[1]), .BUS1_ACK_OUT(ack[1]),
    .BUS1_ALERT_N_OUT(al[1]), .POWER_ON_OUT(pwr), .CC_HOLD_OUT(), .ALARM_CLEAR_OUT(),
    .RESTART_OK_OUT(rok), .OUTPUT_LED_OUT(ol), .SERVICE_LED_OUT(sl), .FAULT_LED_OUT(fl),
    .INPUT_LED_OUT(il), .STRETCH_OUT(strch), .ORING_TEST_OUT(orng)
  );
  host_pair_model u_host_pair_model (
    .lclk_in(lclk), .ack_in(ack), .stb_out(stb), .kind_out(kd), .data_out(dt), .pec_out(pe)
  );
  // ====================
  // Helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    xs = s ^ (s << 5);
  endfunction : xs
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s exp %0h seen %0h", nm, exp, seen);
    end
  endtask : chk
  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : results
  // Write: code, one byte unless takeover or clear, then end
  task automatic wr(input int p, input logic [7:0] c, input logic [7:0] b, input logic ok);
    u_host_pair_model.xfer(p, LK_CMD, c, 1'b0);
    if (c != CMD_TAKEOVER && c != CMD_CLEAR_FAULTS) u_host_pair_model.xfer(p, LK_DATA, b, 1'b0);
    u_host_pair_model.xfer(p, LK_END, 8'h00, ok);
    repeat (3) @(negedge clk);
  endtask : wr
  task automatic rd(input int p, input logic [7:0] c);
    u_host_pair_model.xfer(p, LK_READ, c, 1'b0);
    repeat (2) @(negedge clk);
    r = rdv[p];
  endtask : rd
  // Cycles while the watched outputs hold a pattern, bounded
  task automatic span(input logic [4:0] m, input logic [4:0] x, input int lim);
    n = 0;
    @(negedge clk);
    while ((obs & m) === x && n < lim) begin
      @(negedge clk);
      n++;
    end
  endtask : span
  // Hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 99000) begin
      error_cnt++;
      results();
    end
  end
  // ====================
  // Main sequence
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (8) @(posedge clk);
    rd(0, CMD_BUS_STATE);
    chk("bus0 state", r, 8'h01);
    rd(1, CMD_BUS_STATE);
    chk("bus1 state", r, 8'h01);
    chk("power", pwr, 1'b1);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      v = seed[7:0] & 8'hf0;
      repeat (120) @(posedge clk);
      wr(0, CMD_TEST_FUNC, v, 1'b1);
      chk("oring", orng, v[TF_ORING]);
      chk("stretch", strch, sp);
      sp = v[TF_STRETCH];
    end
    wr(0, CMD_TEST_FUNC, 8'h00, 1'b1);
    wr(1, CMD_TEST_FUNC, 8'h10, 1'b1);
    chk("refused", orng, 1'b0);
    wr(1, CMD_TAKEOVER, 8'h00, 1'b0);
    rd(1, CMD_BUS_STATE);
    chk("bad check", r, 8'h81);
    wr(1, CMD_TAKEOVER, 8'h00, 1'b1);
    chk("alerts", al, 2'h0);
    rd(0, CMD_BUS_STATE);
    chk("takeover", r & 8'h55, 8'h54);
    wr(1, CMD_CLEAR_FAULTS, 8'h00, 1'b1);
    chk("alert1", al, 2'h2);
    wr(0, CMD_CLEAR_FAULTS, 8'h00, 1'b1);
    chk("alert0", al, 2'h3);
    v = seed[15:8] | 8'h01;
    u_host_pair_model.xfer(1, LK_CMD, CMD_MEM_WRITE, 1'b0);
    repeat (3) u_host_pair_model.xfer(1, LK_DATA, v, 1'b0);
    u_host_pair_model.xfer(1, LK_END, 8'h00, 1'b1);
    wr(1, CMD_MEM_WRITE, v, 1'b1);
    rd(1, CMD_MEM_WRITE);
    chk("memory", r, v);
    $display("test host control done");
    wr(1, CMD_TEST_FUNC, 8'h02, 1'b1);
    span(5'h04, 5'h04, 3000);
    span(5'h04, 5'h00, 3000);
    span(5'h04, 5'h04, 3000);
    chk("flash", (n + 2) / T, FLASH_HALF_MS);
    wr(1, CMD_TEST_FUNC, 8'h00, 1'b1);
    chk("svc off", sl, 1'b0);
    wr(1, CMD_TEST_FUNC, 8'h01, 1'b1);
    span(5'h0f, 5'h0f, 40000);
    chk("led on", (n + 5 * T) / (10 * T), LEDTEST_ON_MS / 10);
    span(5'h0f, 5'h00, 40000);
    chk("led off", (n + 5 * T) / (10 * T), LEDTEST_OFF_MS / 10);
    wr(1, CMD_TEST_FUNC, 8'h00, 1'b1);
    chk("leds out", {sl, fl}, 2'h0);
    chk("out led", ol, 1'b1);
    $display("test leds done");
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      flt[i] <= 1'b1;
      span(5'h10, 5'h10, 200);
      @(posedge clk);
      flt[i] <= 1'b0;
      span(5'h10, 5'h00, 9000);
      chk("retry", (n + 200) / (100 * T), RETRY_MS / 100);
    end
    repeat (400) @(posedge clk);
    chk("restart ok", rok, 1'b1);
    wr(0, CMD_CLEAR_FAULTS, 8'h00, 1'b1);
    chk("fault alert", al, 2'h0);
    lat <= 3'h4;
    for (int m = 0; m < 2; m++) begin
      @(posedge clk);
      flt[2] <= 1'b1;
      span(5'h10, 5'h10, 200);
      @(posedge clk);
      flt[2] <= 1'b0;
      span(5'h10, 5'h00, 5000);
      chk("latched", n, 5000);
      @(posedge clk);
      run[m] <= 1'b0;
      repeat (8800) @(posedge clk);
      run[m] <= 1'b1;
      span(5'h10, 5'h00, 100);
      chk("relaunch", pwr, 1'b1);
    end
    $display("test power done");
    results();
  end
endmodule : tb_top
